// File: src/interrupt_pin_control.sv
// Interrupt pin routing, drive and trigger-input logic
//
// Contract
// R1 - A pin is driven only while its drive-on bit (7 second, 3 first) is 1.
// R2 - Open-drain bit (6 second, 2 first): 0 push-pull, 1 open drain.
// R3 - Polarity bit (5 second, 1 first): 0 active low, 1 active high.
// R4 - With drive off, the polarity bit sets the trigger input level.
// R5 - Frame tagging from a pin ignores that pin's polarity bit.
// R6 - Edge-select bit (4 second, 0 first): 1 edge, 0 level.
// R7 - Edge-or-level shapes the output only while drive-on is 1.
// R8 - A pin is an input only when its input enable (5 second, 4 first) is 1; the frame tag samples the pin even with it 0.
// R9 - First pin routing: bit 7 ready, 6 watermark, 5 full, 4 reserved.
// R10 - Second pin routing: bit 3 ready, 2 watermark, 1 full, 0 reserved.
// R11 - A routing bit of 1 makes the route active, 0 keeps it inactive.
// R12 - With the external interrupt routed, all other mappings are off.
// R13 - While the external interrupt is routed, the host disables others.
// R14 - A pin used as power-mode trigger honours its edge-or-level bit.
// R15 - Watermark rises when stored entries exceed the level (4-byte units).
// R16 - A pin's request is the OR of sources both enabled and routed to it.
`timescale 1ns/1ps
`default_nettype none

module interrupt_pin_control #(
	parameter int FILL_WIDTH = 8
) (
	// Clock and reset
	input  wire logic                  core_clk,
	input  wire logic                  reset_n,
	// Register port
	input  wire logic [7:0]            regAddr,
	input  wire logic [7:0]            regWrData,
	input  wire logic                  regWrite,
	input  wire logic                  regRead,
	output logic      [7:0]            regRdData,
	// Interrupt sources and their enables
	input  wire logic                  dataReady,
	input  wire logic                  fifoFull,
	input  wire logic [FILL_WIDTH-1:0] fifoEntries,
	input  wire logic [FILL_WIDTH-1:0] watermarkLevel,
	input  wire logic [2:0]            srcEnable,
	// External interrupt routing, bit 0 first pin
	input  wire logic                  extIrq,
	input  wire logic [1:0]            extRouted,
	// Frame tag enables, one input per pin, first pin then second
	input  wire logic                  queueTagFirstPin,
	input  wire logic                  queueTagSecondPin,
	// Pins, bit 0 first pin, bit 1 second pin
	input  wire logic [1:0]            irqPinIn,
	output logic      [1:0]            irqPinOut,
	output logic      [1:0]            irqPinOe_n,
	// Power-mode triggers and frame tags
	output logic      [1:0]            pmuTrigger,
	output logic      [1:0]            frameTag
);
	// Compare logic is not planned for fill counts wider than 16 bits
	if (FILL_WIDTH < 1 || FILL_WIDTH > 16) begin : fillWidthCheck
		$error("FILL_WIDTH out of range");
	end

	typedef struct packed {
		logic [7:0] outSetup;
		logic [7:0] inSetup;
		logic [7:0] routing;
		logic [7:0] rdData;
		logic [1:0] syncA;
		logic [1:0] syncB;
		logic [1:0] reqPrev;
		logic [1:0] inPrev;
		logic [1:0] pinOut;
		logic [1:0] pinOeN;
		logic [1:0] trig;
		logic [1:0] tag;
	} state_s;

	state_s st;
	state_s next_st;
	logic   [1:0] req;
	logic   [1:0] inActive;
	logic         watermarkHit;

	// Watermark source
	// R15 - strict exceed compare
	assign watermarkHit = fifoEntries > watermarkLevel;

	always_comb begin
		logic [3:0] cfg;
		logic [2:0] route;
		logic       asserted;
		logic       lvl;
		int         base;
		cfg = '0;
		route = '0;
		asserted = 1'b0;
		lvl = 1'b0;
		base = 0;
		next_st = st;
		req = '0;
		inActive = '0;
		next_st.syncA = irqPinIn;
		next_st.syncB = st.syncA;
		next_st.rdData = 8'h00;
		// Register writes; reserved bits stay zero
		if (regWrite) begin
			unique case (regAddr)
				irq_pin_pkg::OUTPUT_SETUP_OFS: next_st.outSetup = regWrData;
				irq_pin_pkg::INPUT_SETUP_OFS:
					next_st.inSetup = regWrData & irq_pin_pkg::INPUT_SETUP_MASK;
				irq_pin_pkg::SOURCE_ROUTE_OFS:
					next_st.routing = regWrData & irq_pin_pkg::SOURCE_ROUTE_MASK;
				default: ;
			endcase
		end
		// Reads answer one cycle later; unmapped reads give zero
		if (regRead) begin
			unique case (regAddr)
				irq_pin_pkg::OUTPUT_SETUP_OFS: next_st.rdData = st.outSetup;
				irq_pin_pkg::INPUT_SETUP_OFS:  next_st.rdData = st.inSetup;
				irq_pin_pkg::SOURCE_ROUTE_OFS: next_st.rdData = st.routing;
				default:                       next_st.rdData = 8'h00;
			endcase
		end
		for (int p = 0; p < irq_pin_pkg::NUM_PINS; p++) begin
			base = p * irq_pin_pkg::PIN_NIBBLE;
			cfg = st.outSetup[base +: 4];
			// R9 R10 - routing bit positions per pin
			route = (p == 0) ? st.routing[irq_pin_pkg::ROUTE_FIRST_BASE +: 3]
			                 : st.routing[irq_pin_pkg::ROUTE_SECOND_BASE +: 3];
			// R12 - external interrupt replaces all other mappings
			if (extRouted[p]) begin
				req[p] = extIrq;
			end else begin
				// R11 R16 - OR of enabled and routed sources
				req[p] = (route[irq_pin_pkg::ROUTE_DRDY_OFS] & srcEnable[2]
				          & dataReady)
				       | (route[irq_pin_pkg::ROUTE_FWM_OFS] & srcEnable[1]
				          & watermarkHit)
				       | (route[irq_pin_pkg::ROUTE_FFULL_OFS] & srcEnable[0]
				          & fifoFull);
			end
			next_st.reqPrev[p] = req[p];
			// R6 R7 - edge gives a one-cycle pulse, level follows request
			asserted = cfg[irq_pin_pkg::EDGE_SEL_POS] ? (req[p] & ~st.reqPrev[p])
			                                          : req[p];
			// R3 - active level comes from the polarity bit
			lvl = cfg[irq_pin_pkg::POLARITY_POS] ? asserted : ~asserted;
			// R1 R2 - drive only when enabled; open drain only pulls low
			if (!cfg[irq_pin_pkg::DRIVE_ON_POS]) begin
				next_st.pinOut[p] = 1'b0;
				next_st.pinOeN[p] = 1'b1;
			end else if (cfg[irq_pin_pkg::OPENDRAIN_POS]) begin
				next_st.pinOut[p] = 1'b0;
				next_st.pinOeN[p] = lvl;
			end else begin
				next_st.pinOut[p] = lvl;
				next_st.pinOeN[p] = 1'b0;
			end
			// R4 R8 - trigger input only with drive off and input enabled
			inActive[p] = ~cfg[irq_pin_pkg::DRIVE_ON_POS]
			            & st.inSetup[irq_pin_pkg::INPUT_EN_BASE + p]
			            & (st.syncB[p] == cfg[irq_pin_pkg::POLARITY_POS]);
			next_st.inPrev[p] = inActive[p];
			// R14 - trigger honours edge or level selection
			next_st.trig[p] = cfg[irq_pin_pkg::EDGE_SEL_POS]
			                ? (inActive[p] & ~st.inPrev[p]) : inActive[p];
		end
		// R5 - tag samples the raw pin level, polarity not applied
		next_st.tag[0] = queueTagFirstPin & st.syncB[0];
		next_st.tag[1] = queueTagSecondPin & st.syncB[1];
	end

	// Constant reset; pins released while in reset
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			st <= '{outSetup: irq_pin_pkg::OUTPUT_SETUP_RST,
			        inSetup:  irq_pin_pkg::INPUT_SETUP_RST,
			        routing:  irq_pin_pkg::SOURCE_ROUTE_RST,
			        pinOeN:   2'h3,
			        default:  '0};
		end else begin
			st <= next_st;
		end
	end

	assign regRdData  = st.rdData;
	assign irqPinOut  = st.pinOut;
	assign irqPinOe_n = st.pinOeN;
	assign pmuTrigger = st.trig;
	assign frameTag   = st.tag;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	drive_off_a: assert property ( // R1
		!st.outSetup[3] ##1 !st.outSetup[3] |-> irqPinOe_n[0] && !irqPinOut[0]
	) else $error("first pin driven while drive is off");

	pushpull_on_a: assert property ( // R2
		st.outSetup[7] && !st.outSetup[6] |=> !irqPinOe_n[1]
	) else $error("second pin push-pull not driving");

	level_polarity_a: assert property ( // R3
		st.outSetup[3:0] == 4'ha && req[0] |=> irqPinOut[0] && !irqPinOe_n[0]
	) else $error("first pin active-high level not shown");

	trig_level_a: assert property ( // R4
		st.outSetup[3:0] == 4'h0 && st.inSetup[4] && !st.syncB[0]
		|=> pmuTrigger[0]
	) else $error("first pin low-active trigger missed");

	tag_raw_a: assert property ( // R5
		queueTagSecondPin && st.syncB[1] |=> frameTag[1]
	) else $error("frame tag lost");

	edge_pulse_a: assert property ( // R6
		st.outSetup[3:0] == 4'hb && $stable(st.outSetup)
		|=> !(irqPinOut[0] && $past(irqPinOut[0]))
	) else $error("edge output held for more than one cycle");

	input_gate_a: assert property ( // R8
		!st.inSetup[5] |=> !pmuTrigger[1]
	) else $error("second pin trigger without input enable");

	route_off_a: assert property ( // R11
		st.routing[7:5] == 3'h0 && !extRouted[0] |-> !req[0]
	) else $error("request on first pin without routing");

	ext_only_a: assert property ( // R12
		extRouted[1] |-> req[1] == extIrq
	) else $error("other source reached pin with external routed");

	watermark_a: assert property ( // R15
		st.routing[2] && srcEnable[1] && !extRouted[1]
		&& fifoEntries > watermarkLevel |-> req[1]
	) else $error("watermark not raised");
endmodule

`default_nettype wire

// File: src/irq_pin_pkg.sv
// Register offsets, field positions and reset values of the interrupt pins
package irq_pin_pkg;
	localparam logic [7:0] OUTPUT_SETUP_OFS  = 8'h53;
	localparam logic [7:0] INPUT_SETUP_OFS   = 8'h54;
	localparam logic [7:0] SOURCE_ROUTE_OFS  = 8'h56;
	localparam logic [7:0] OUTPUT_SETUP_RST  = 8'h00;
	localparam logic [7:0] INPUT_SETUP_RST   = 8'h00;
	localparam logic [7:0] SOURCE_ROUTE_RST  = 8'h00;
	// Per pin nibble in the output setup: pin p uses bits 4p+3..4p
	localparam int         PIN_NIBBLE        = 4;
	localparam int         DRIVE_ON_POS      = 3;
	localparam int         OPENDRAIN_POS     = 2;
	localparam int         POLARITY_POS      = 1;
	localparam int         EDGE_SEL_POS      = 0;
	// Input enables: first pin bit 4, second pin bit 5
	localparam int         INPUT_EN_BASE     = 4;
	localparam logic [7:0] INPUT_SETUP_MASK  = 8'h30;
	// Routing: first pin base bit 5, second pin base bit 1
	localparam int         ROUTE_FIRST_BASE  = 5;
	localparam int         ROUTE_SECOND_BASE = 1;
	localparam int         ROUTE_FFULL_OFS   = 0;
	localparam int         ROUTE_FWM_OFS     = 1;
	localparam int         ROUTE_DRDY_OFS    = 2;
	localparam logic [7:0] SOURCE_ROUTE_MASK = 8'hee;
	localparam int         NUM_PINS          = 2;
endpackage

// File: test/irq_host_model.sv
// Host side of the two interrupt pins with board pull-ups
`timescale 1ns/1ps
`default_nettype none

module irq_host_model (
	// Device side of the pins
	input  wire logic [1:0] irqPinOut,
	input  wire logic [1:0] irqPinOe_n,
	// Host drive for trigger use
	input  wire logic [1:0] hostDrive,
	input  wire logic [1:0] hostLevel,
	// Resolved pin level
	output logic      [1:0] pinWire
);
	// device drives only with Oe_n low, else host level when hostDrive is set, pull-up otherwise
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			pinWire[i] = !irqPinOe_n[i] ? irqPinOut[i] :
				hostDrive[i] ? hostLevel[i] : 1'b1;
		end
	end
endmodule
`default_nettype wire

// File: test/tb.sv
// Self-checking bench for the interrupt pin control block
`timescale 1ns/1ps
`default_nettype none

module tb;
	logic       core_clk = 1'b0, reset_n = 1'b0;
	logic [7:0] regAddr, regWrData, regRdData, ents, wml;
	logic       regWrite, regRead, dataReady, fifoFull, extIrq, tag1, tag2;
	logic [2:0] srcEnable;
	logic [1:0] extRouted, pinOut, oeN, pmu, ftag, hDrv, hLvl, pinW;
	int         miscompares = 0, total_checks = 0;

	always #12.5 core_clk = ~core_clk;

	interrupt_pin_control dut_u (.core_clk(core_clk), .reset_n(reset_n),
		.regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
		.regRead(regRead), .regRdData(regRdData), .dataReady(dataReady),
		.fifoFull(fifoFull), .fifoEntries(ents), .watermarkLevel(wml),
		.srcEnable(srcEnable), .extIrq(extIrq), .extRouted(extRouted),
		.queueTagFirstPin(tag1), .queueTagSecondPin(tag2),
		.irqPinIn(pinW), .irqPinOut(pinOut), .irqPinOe_n(oeN),
		.pmuTrigger(pmu), .frameTag(ftag));
	irq_host_model host_u (.irqPinOut(pinOut), .irqPinOe_n(oeN),
		.hostDrive(hDrv), .hostLevel(hLvl), .pinWire(pinW));

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		{regAddr, regWrData, regWrite} = {a, d, 1'b1};
		@(negedge core_clk) regWrite = 1'b0;
		// Idle edge so back-to-back calls never retoggle the strobe
		@(negedge core_clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		{regAddr, regRead} = {a, 1'b1};
		@(negedge core_clk) regRead = 1'b0;
		chk(regRdData, exp);
		@(negedge core_clk);
	endtask
	// Wait n edges then compare pin state {pinW, oeN, pinOut}
	task automatic pins(input int n, input logic [5:0] exp);
		repeat (n) @(negedge core_clk);
		chk({2'h0, pinW, oeN, pinOut}, {2'h0, exp});
	endtask

	task automatic t_regs;
		rd(8'h53, 8'h00);
		rd(8'h54, 8'h00);
		rd(8'h56, 8'h00);
		wr(8'h54, 8'hff);
		rd(8'h54, 8'h30);
		wr(8'h56, 8'hff);
		rd(8'h56, 8'hee);
		rd(8'h40, 8'h00);
		pins(1, 6'h3c);
		$display("test regs done");
	endtask

	task automatic t_first;
		{srcEnable, dataReady} = 4'h9;
		wr(8'h56, 8'h80);
		wr(8'h53, 8'h0a);
		pins(1, 6'h39);
		wr(8'h53, 8'h08);
		pins(1, 6'h28);
		wr(8'h53, 8'h0e);
		pins(1, 6'h3c);
		dataReady = 1'b0;
		pins(2, 6'h28);
		wr(8'h53, 8'h0b);
		dataReady = 1'b1;
		pins(1, 6'h39);
		pins(1, 6'h28);
		wr(8'h56, 8'h00);
		pins(1, 6'h28);
		$display("test first pin done");
	endtask

	task automatic t_second;
		{dataReady, srcEnable, ents, wml} = {4'h2, 8'h05, 8'h05};
		wr(8'h53, 8'ha0);
		wr(8'h56, 8'h04);
		pins(1, 6'h14);
		ents = 8'h06;
		pins(2, 6'h36);
		// host keeps sources off while external routed
		{srcEnable, extRouted, extIrq} = 6'h04;
		pins(2, 6'h14);
		extIrq = 1'b1;
		pins(2, 6'h36);
		{extRouted, extIrq, ents} = {3'h0, 8'h00};
		$display("test second pin done");
	endtask

	task automatic t_trigger;
		wr(8'h53, 8'h00);
		wr(8'h54, 8'h10);
		{tag1, tag2, hDrv, hLvl} = 6'h34;
		pins(3, 6'h2c);
		chk({6'h0, pmu}, 8'h01);
		chk({6'h0, ftag}, 8'h02);
		hLvl = 2'h1;
		repeat (3) @(negedge core_clk);
		chk({6'h0, pmu}, 8'h00);
		chk({6'h0, ftag}, 8'h03);
		wr(8'h54, 8'h00);
		hLvl = 2'h0;
		repeat (4) @(negedge core_clk);
		chk({6'h0, pmu}, 8'h00);
		hLvl = 2'h1;
		wr(8'h53, 8'h01);
		wr(8'h54, 8'h10);
		hLvl = 2'h0;
		repeat (3) @(negedge core_clk);
		chk({6'h0, pmu}, 8'h01);
		@(negedge core_clk);
		chk({6'h0, pmu}, 8'h00);
		$display("test trigger done");
	endtask

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	initial begin
		{regAddr, regWrData, regWrite, regRead, dataReady} = 0;
		{fifoFull, ents, wml, srcEnable, extIrq, extRouted} = 0;
		{tag1, tag2, hDrv, hLvl} = 0;
		repeat (10) @(posedge core_clk);
		@(negedge core_clk) reset_n = 1'b1;
		t_regs();
		t_first();
		t_second();
		t_trigger();
		tally_and_finish();
	end

	initial begin
		#200000;
		miscompares++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
